// *** logic/mace_regs.vh ***
`ifndef MACE_REGS_VH
`define MACE_REGS_VH
// special function register addresses (page 3)
`define MACE_ADDR_STATUS    8'hC0
`define MACE_ADDR_A_LOW     8'hC1
`define MACE_ADDR_A_HIGH    8'hC2
`define MACE_ADDR_CONFIG    8'hC3
`define MACE_ADDR_ACC0      8'h93
`define MACE_ADDR_ACC1      8'h94
`define MACE_ADDR_ACC2      8'h95
`define MACE_ADDR_ACC3      8'h96
`define MACE_ADDR_ACC_TOP   8'h97
`define MACE_ADDR_B_LOW     8'h91
`define MACE_ADDR_B_HIGH    8'h92
`define MACE_ADDR_ROUND_H   8'hCF
`define MACE_ADDR_ROUND_L   8'hCE
`define MACE_PAGE           8'h03
// configuration fields
`define MACE_CF_SHIFT_GO    5
`define MACE_CF_SHIFT_DIR   4
`define MACE_CF_CLEAR       3
`define MACE_CF_SATURATE    2
`define MACE_CF_FRACTIONAL  1
`define MACE_CF_MULT_ONLY   0
`define MACE_CF_MASK        8'h3F
// status fields
`define MACE_ST_HARD_OVF    3
`define MACE_ST_ZERO        2
`define MACE_ST_SOFT_OVF    1
`define MACE_ST_NEGATIVE    0
`define MACE_ST_MASK        8'h0F
`define MACE_ST_RESET       8'h04
`define MACE_CF_RESET       8'h00
// rounding and hard overflow constants
`define MACE_HALF           16'h8000
`define MACE_POS_SAT        16'h7FFF
`define MACE_NEG_SAT        16'h8000
`define MACE_TOP_POS        8'h7F
`define MACE_TOP_NEG        8'h80
`endif

// *** logic/mace_round.v ***
`include "mace_regs.vh"
// rounding stage: registered round-half-to-even of bits 31..16 with optional saturation
module mace_round (
  input  wire        clock,
  input  wire        rst,
  input  wire        load,
  input  wire [39:0] acc,
  input  wire        saturate,
  output reg  [15:0] rounded
);
  wire [15:0] upper    = acc[31:16];
  wire [15:0] lower    = acc[15:0];
  wire        round_up = (lower > `MACE_HALF) || ((lower == `MACE_HALF) && upper[0]);
  wire [16:0] sum      = {upper[15], upper} + {16'h0000, round_up};
  // out of 16-bit signed range: from the guard bits or from rounding
  wire        hi_ext   = ~(&acc[39:31]) & (|acc[39:31]);
  wire        rnd_ovf  = sum[16] != sum[15];
  wire        overflow = hi_ext | rnd_ovf;
  wire        negative = acc[39];
  reg  [15:0] next_rounded;

  always @*
  begin
    next_rounded = sum[15:0];
    if (saturate && overflow)
      next_rounded = negative ? `MACE_NEG_SAT : `MACE_POS_SAT;
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      rounded <= 16'h0000;
    else if (load)
      rounded <= next_rounded;
  end
endmodule // mace_round

// *** logic/mace_engine.v ***
`include "mace_regs.vh"
module mace_engine (
  input  wire        clock,
  input  wire        rst,
  input  wire        sfr_write,
  input  wire        sfr_read,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_page,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  output wire        sfr_hit
);
  reg  [7:0]  config_reg;
  reg  [3:0]  status_reg;
  reg  [7:0]  operand_a_high;
  reg  [7:0]  operand_a_low;
  reg  [7:0]  operand_b_high;
  reg  [7:0]  operand_b_low;
  reg  [39:0] acc;
  reg         stage1;
  reg         stage2;
  reg         round_load;
  reg  [31:0] product;
  wire [15:0] rounded;
  reg  [39:0] next_acc;
  reg  [3:0]  next_status;
  reg  [7:0]  next_config;
  reg  [7:0]  next_rdata;
  reg         addr_mapped;
  wire [4:0]  acc_byte_wr;
  wire [39:0] acc_loaded;

  // accumulator byte addresses, byte zero in the low slot
  localparam [39:0] ACC_ADDRS     = {`MACE_ADDR_ACC_TOP, `MACE_ADDR_ACC3, `MACE_ADDR_ACC2,
                                     `MACE_ADDR_ACC1, `MACE_ADDR_ACC0};
  localparam [7:0]  ST_RESET_BYTE = `MACE_ST_RESET;

  wire on_page  = sfr_page == `MACE_PAGE;
  wire wr       = sfr_write & on_page;
  wire wr_cfg   = wr && sfr_addr == `MACE_ADDR_CONFIG;
  wire wr_sta   = wr && sfr_addr == `MACE_ADDR_STATUS;
  wire wr_bl    = wr && sfr_addr == `MACE_ADDR_B_LOW;
  wire wr_ah    = wr && sfr_addr == `MACE_ADDR_A_HIGH;
  wire wr_al    = wr && sfr_addr == `MACE_ADDR_A_LOW;
  wire wr_bh    = wr && sfr_addr == `MACE_ADDR_B_HIGH;

  // one write strobe and one merged byte per accumulator register
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_acc_byte
      assign acc_byte_wr[gi]         = wr && sfr_addr == ACC_ADDRS[8 * gi +: 8];
      assign acc_loaded[8 * gi +: 8] = acc_byte_wr[gi] ? sfr_wdata
                                                       : acc[8 * gi +: 8];
    end
  endgenerate

  wire shift_go             = config_reg[`MACE_CF_SHIFT_GO];
  wire shift_direction      = config_reg[`MACE_CF_SHIFT_DIR];
  wire clear_accumulator    = config_reg[`MACE_CF_CLEAR];
  wire saturate_enable      = config_reg[`MACE_CF_SATURATE];
  wire fractional_select    = config_reg[`MACE_CF_FRACTIONAL];
  wire multiply_only_select = config_reg[`MACE_CF_MULT_ONLY];

  wire [15:0] operand_a = {operand_a_high, operand_a_low};
  wire [15:0] operand_b = {operand_b_high, operand_b_low};

  // stage 1: signed 16x16 multiply, fractional mode shifts left by one
  wire signed [31:0] raw_product = $signed(operand_a) * $signed(operand_b);
  wire [31:0] scaled = fractional_select ? {raw_product[30:0], 1'b0}
                                         : raw_product;
  wire [39:0] product_ext = {{8{product[31]}}, product};
  wire [39:0] addend      = multiply_only_select ? 40'h0000000000 : acc;
  wire [39:0] sum         = addend + product_ext;
  // hard overflow: the top byte steps across the 0x7F/0x80 boundary
  wire [7:0]  top_before  = acc[39:32];
  wire [7:0]  top_after   = sum[39:32];
  wire        hard_cross  = (top_before == `MACE_TOP_POS && top_after == `MACE_TOP_NEG) ||
                            (top_before == `MACE_TOP_NEG && top_after == `MACE_TOP_POS);
  // flags taken from the freshly accumulated value
  wire        sum_zero    = sum == 40'h0000000000;
  wire        sum_negative = sum[39];
  // soft overflow: bits 39..31 no longer agree with the sign at bit 31
  wire        soft_ovf    = sum[39:31] != {9{sum[31]}};
  wire [39:0] shifted     = shift_direction ? {acc[39], acc[39:1]}
                                            : {acc[38:0], 1'b0};

  // pipeline: start write, then product register, then accumulator update
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end
    else
    begin
      stage1 <= wr_bl;
      stage2 <= stage1;
    end
  end

  // stage one result, taken from the operands as they stand then
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      product <= 32'h00000000;
    else if (stage1)
      product <= scaled;
  end

  // accumulator and status; clear wins over an operation or a shift
  always @*
  begin
    next_acc    = acc;
    next_status = status_reg;
    if (clear_accumulator)
    begin
      next_acc    = 40'h0000000000;
      next_status = ST_RESET_BYTE[3:0];
    end
    else if (stage2)
    begin
      next_acc = sum;
      // a status write in stage two reaches only the hard overflow bit; the set wins
      if (hard_cross && !multiply_only_select)
        next_status[`MACE_ST_HARD_OVF] = 1'b1;
      else if (wr_sta)
        next_status[`MACE_ST_HARD_OVF] = sfr_wdata[`MACE_ST_HARD_OVF];
      next_status[`MACE_ST_ZERO]     = sum_zero;
      next_status[`MACE_ST_SOFT_OVF] = soft_ovf;
      next_status[`MACE_ST_NEGATIVE] = sum_negative;
    end
    else
    begin
      // shifts leave the flags alone
      if (shift_go)
        next_acc = shifted;
      else
        next_acc = acc_loaded;
      if (wr_sta)
        next_status = sfr_wdata[3:0];
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc        <= 40'h0000000000;
      status_reg <= ST_RESET_BYTE[3:0];
    end
    else
    begin
      acc        <= next_acc;
      status_reg <= next_status;
    end
  end

  // configuration: shift and clear bits drop after one cycle, even where clear or stage two keeps the shift from running
  always @*
  begin
    next_config = config_reg;
    if (wr_cfg)
      next_config = sfr_wdata & `MACE_CF_MASK;
    else
    begin
      if (shift_go)
        next_config[`MACE_CF_SHIFT_GO] = 1'b0;
      if (clear_accumulator)
        next_config[`MACE_CF_CLEAR] = 1'b0;
    end
  end

  // configuration and operands
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      config_reg     <= `MACE_CF_RESET;
      operand_a_high <= 8'h00;
      operand_a_low  <= 8'h00;
      operand_b_high <= 8'h00;
      operand_b_low  <= 8'h00;
    end
    else
    begin
      config_reg <= next_config;
      if (wr_ah) operand_a_high <= sfr_wdata;
      if (wr_al) operand_a_low  <= sfr_wdata;
      if (wr_bh) operand_b_high <= sfr_wdata;
      if (wr_bl) operand_b_low  <= sfr_wdata;
    end
  end

  // rounding follows the cycle after an operation, a shift or a low byte write
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      round_load <= 1'b0;
    else
      round_load <= stage2 | (shift_go & ~clear_accumulator) | acc_byte_wr[0];
  end

  mace_round u_round (
    .clock    (clock),
    .rst      (rst),
    .load     (round_load),
    .acc      (acc),
    .saturate (saturate_enable),
    .rounded  (rounded)
  );

  // address decode for the hit flag
  always @*
  begin
    addr_mapped = 1'b0;
    case (sfr_addr)
      `MACE_ADDR_STATUS,
      `MACE_ADDR_A_LOW,
      `MACE_ADDR_A_HIGH,
      `MACE_ADDR_CONFIG,
      `MACE_ADDR_ACC0,
      `MACE_ADDR_ACC1,
      `MACE_ADDR_ACC2,
      `MACE_ADDR_ACC3,
      `MACE_ADDR_ACC_TOP,
      `MACE_ADDR_B_LOW,
      `MACE_ADDR_B_HIGH,
      `MACE_ADDR_ROUND_H,
      `MACE_ADDR_ROUND_L:
        addr_mapped = 1'b1;
      default:
        addr_mapped = 1'b0;
    endcase
  end

  assign sfr_hit = sfr_read & on_page & addr_mapped;

  // read mux: zero for idle cycles and for unmapped or off-page reads
  always @*
  begin
    next_rdata = 8'h00;
    if (sfr_read && on_page)
    begin
      case (sfr_addr)
        `MACE_ADDR_STATUS:  next_rdata = {4'h0, status_reg};
        `MACE_ADDR_CONFIG:  next_rdata = config_reg & `MACE_CF_MASK;
        `MACE_ADDR_A_LOW:   next_rdata = operand_a_low;
        `MACE_ADDR_A_HIGH:  next_rdata = operand_a_high;
        `MACE_ADDR_B_LOW:   next_rdata = operand_b_low;
        `MACE_ADDR_B_HIGH:  next_rdata = operand_b_high;
        `MACE_ADDR_ACC0:    next_rdata = acc[7:0];
        `MACE_ADDR_ACC1:    next_rdata = acc[15:8];
        `MACE_ADDR_ACC2:    next_rdata = acc[23:16];
        `MACE_ADDR_ACC3:    next_rdata = acc[31:24];
        `MACE_ADDR_ACC_TOP: next_rdata = acc[39:32];
        `MACE_ADDR_ROUND_H: next_rdata = rounded[15:8];
        `MACE_ADDR_ROUND_L: next_rdata = rounded[7:0];
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  // read data stands for one cycle after the read strobe
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= next_rdata;
  end
endmodule // mace_engine

// *** tb/mace_engine_properties.sv ***
`include "mace_regs.vh"
module mace_chk (
  input wire       clock,
  input wire       rst,
  input wire       sfr_write,
  input wire       sfr_read,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_page,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire       sfr_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire p3 = sfr_page == `MACE_PAGE;
  wire in_map = sfr_addr[7:2] == 6'h30 || (sfr_addr > 8'h90 && sfr_addr < 8'h98)
    || sfr_addr[7:1] == 7'h67;
  sequence s_wr(a);
    sfr_write && p3 && sfr_addr == a;
  endsequence
  sequence s_rd(a);
    sfr_read && p3 && !sfr_write && sfr_addr == a;
  endsequence
  rdata_idle_a: assert property (!sfr_read |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  off_page_a: assert property (sfr_read && !p3 |-> !sfr_hit ##1 sfr_rdata == 8'h00)
    else $error("off-page read answered");
  unmapped_a: assert property (sfr_read && p3 && !in_map |-> !sfr_hit ##1 sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  mapped_hit_a: assert property (sfr_read && p3 && in_map |-> sfr_hit)
    else $error("mapped read missed");
  cfg_top_a: assert property (s_rd(`MACE_ADDR_CONFIG) |=> sfr_rdata[7:6] == 2'b00)
    else $error("config top bits set");
  sta_top_a: assert property (s_rd(`MACE_ADDR_STATUS) |=> sfr_rdata[7:4] == 4'h0)
    else $error("status top bits set");
  cfg_readback_a: assert property (s_wr(`MACE_ADDR_CONFIG) ##1 !sfr_write ##1
    s_rd(`MACE_ADDR_CONFIG) |=> (sfr_rdata & 8'h3F) == ($past(sfr_wdata, 3) & 8'h17))
    else $error("config readback wrong");
  clear_sta_a: assert property (!sfr_write [*2] ##1 s_wr(`MACE_ADDR_CONFIG)
    ##0 sfr_wdata[3] ##1 !sfr_write ##1 s_rd(`MACE_ADDR_STATUS) |=> sfr_rdata == 8'h04)
    else $error("clear left status");
  sta_write_a: assert property (!sfr_write [*2] ##1 s_wr(`MACE_ADDR_STATUS) ##1
    !sfr_write ##1 s_rd(`MACE_ADDR_STATUS) |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h0F))
    else $error("status write lost");
endmodule // mace_chk

bind mace_engine mace_chk u_chk (.clock(clock), .rst(rst), .sfr_write(sfr_write),
  .sfr_read(sfr_read), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));

// *** tb/mace_cpu.sv ***
`include "mace_regs.vh"
module mace_cpu (
  input  wire       clock,
  output reg        sfr_write,
  output reg        sfr_read,
  output reg  [7:0] sfr_addr,
  output reg  [7:0] sfr_page,
  output reg  [7:0] sfr_wdata,
  input  wire [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {sfr_write, sfr_read, sfr_addr, sfr_wdata} = 18'h0;
    sfr_page = `MACE_PAGE;
  end
  // released lines show the inverse of their last value
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clock);
    {sfr_write, sfr_addr, sfr_wdata} <= {1'b1, a, d};
    @(posedge clock);
    {sfr_write, sfr_addr, sfr_wdata} <= {1'b0, ~a, ~d};
    if (a == `MACE_ADDR_B_LOW) repeat (3) @(posedge clock);
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge clock);
    {sfr_read, sfr_addr} <= {1'b1, a};
    @(posedge clock);
    {sfr_read, sfr_addr} <= {1'b0, ~a};
    #1 d = sfr_rdata;
  end
  endtask
endmodule // mace_cpu

// *** tb/testbench.sv ***
`include "mace_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock;
  logic       rst;
  wire        sfr_write, sfr_read, sfr_hit;
  wire  [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata;
  int         num_errors = 0, checks = 0, cycles = 0;
  logic [7:0] hi, lo;
  mace_cpu u_cpu (.clock(clock), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  mace_engine u_dut (.clock(clock), .rst(rst), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task close_out;
  begin
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      close_out;
    end
  end
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
  begin
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task chk40(input string n, input logic [39:0] e, input logic [39:0] g);
  begin
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
  begin
    u_cpu.rd(a, hi);
    chk8($sformatf("register %h", a), e, hi);
  end
  endtask
  task acc_chk(input [39:0] e);
    logic [39:0] v;
  begin
    for (int i = 0; i < 5; i++)
    begin
      u_cpu.rd(8'h93 + 8'(i), hi);
      v[8 * i +: 8] = hi;
    end
    chk40("accumulator", e, v);
  end
  endtask
  task rnd_chk(input [15:0] e);
  begin
    u_cpu.rd(`MACE_ADDR_ROUND_H, hi);
    u_cpu.rd(`MACE_ADDR_ROUND_L, lo);
    chk40("rounded", {24'h0, e}, {24'h0, hi, lo});
  end
  endtask
  task set_acc(input [39:0] v);
  begin
    for (int i = 4; i >= 0; i--)
      u_cpu.wr(8'h93 + 8'(i), v[8 * i +: 8]);
  end
  endtask
  task op(input [15:0] a, input [15:0] b);
  begin
    u_cpu.wr(`MACE_ADDR_A_HIGH, a[15:8]);
    u_cpu.wr(`MACE_ADDR_A_LOW, a[7:0]);
    u_cpu.wr(`MACE_ADDR_B_HIGH, b[15:8]);
    u_cpu.wr(`MACE_ADDR_B_LOW, b[7:0]);
  end
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rdc(`MACE_ADDR_STATUS, 8'h04);
    rdc(`MACE_ADDR_CONFIG, 8'h00);
    acc_chk(40'h0);
    rnd_chk(16'h0);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'hFF);
    rdc(`MACE_ADDR_CONFIG, 8'h17);
    u_cpu.wr(`MACE_ADDR_STATUS, 8'hFF);
    rdc(`MACE_ADDR_STATUS, 8'h0F);
    u_cpu.wr(`MACE_ADDR_STATUS, 8'h00);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h01);
    op(16'h1234, 16'hFEDC);
    rdc(`MACE_ADDR_A_HIGH, 8'h12);
    rdc(`MACE_ADDR_A_LOW, 8'h34);
    acc_chk(40'hFFFFEB3CB0);
    rdc(`MACE_ADDR_STATUS, 8'h01);
    rnd_chk(16'hFFEB);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h0A);
    rdc(`MACE_ADDR_STATUS, 8'h04);
    acc_chk(40'h0);
    op(16'h4000, 16'h2000);
    acc_chk(40'h0010000000);
    op(16'h4000, 16'hE000);
    acc_chk(40'h0);
    rdc(`MACE_ADDR_STATUS, 8'h04);
    set_acc(40'h4088442211);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h20);
    acc_chk(40'h8110884422);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h30);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h30);
    acc_chk(40'hE044221108);
    rnd_chk(16'h4422);
    set_acc(40'h0000038000);
    rnd_chk(16'h0004);
    set_acc(40'h0000028000);
    rnd_chk(16'h0002);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h00);
    set_acc(40'h7FFFFFFFFF);
    op(16'h0001, 16'h0001);
    acc_chk(40'h8000000000);
    rdc(`MACE_ADDR_STATUS, 8'h0B);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h01);
    u_cpu.wr(`MACE_ADDR_B_LOW, 8'h01);
    acc_chk(40'h1);
    rdc(`MACE_ADDR_STATUS, 8'h08);
    u_cpu.wr(`MACE_ADDR_STATUS, 8'h00);
    rdc(`MACE_ADDR_STATUS, 8'h00);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h04);
    set_acc(40'h0080000000);
    rnd_chk(16'h7FFF);
    acc_chk(40'h0080000000);
    set_acc(40'hFF7FFF0000);
    rnd_chk(16'h8000);
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h00);
    set_acc(40'h0080000000);
    rnd_chk(16'h8000);
    @(posedge clock) u_cpu.sfr_page <= 8'h01;
    u_cpu.wr(`MACE_ADDR_CONFIG, 8'h3F);
    rdc(`MACE_ADDR_STATUS, 8'h00);
    @(posedge clock) u_cpu.sfr_page <= `MACE_PAGE;
    rdc(`MACE_ADDR_CONFIG, 8'h00);
    rdc(8'h90, 8'h00);
    close_out;
  end
endmodule // testbench
